//--- inc/uis_if.sv
// internal signals between the top and its ranking and format units
`timescale 1ns/1ps
`default_nettype none
interface uis_if;
  logic [6:0] src;
  logic       enh;
  logic       rd_ident;
  logic [5:0] code;
  logic       pending;
  logic [7:0] lfc;
  logic       brk;
  logic       dlab;
  logic [3:0] data_bits;
  logic       par_en;
  logic [1:0] par_kind;
  logic [2:0] stop_half;
  modport top  (output src, enh, rd_ident, lfc,
                input code, pending, brk, dlab, data_bits, par_en, par_kind, stop_half);
  modport prio (input src, enh, rd_ident, output code, pending);
  modport fmt  (input lfc, output brk, dlab, data_bits, par_en, par_kind, stop_half);
endinterface
`default_nettype wire

//--- inc/uis_pkg.sv
// shared constants for the interrupt identification and line format slice
package uis_pkg;
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] OFF_IDENT     = 8'h00;
  localparam logic [7:0] OFF_LFC       = 8'h04;
  localparam logic [7:0] OFF_EFR       = 8'h08;
  localparam logic [7:0] OFF_DIV       = 8'h0c;
  localparam logic [7:0] OFF_CTRL      = 8'h10;
  localparam logic [7:0] OFF_EVT       = 8'h14;
  localparam logic [7:0] OFF_MASK      = 8'h18;
  localparam logic [7:0] LFC_RST       = 8'h00;
  localparam logic [7:0] EFR_RST       = 8'h00;
  localparam logic [15:0] DIV_RST      = 16'h0000;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam int         LFC_DLAB      = 7;
  localparam int         LFC_BRK       = 6;
  localparam int         LFC_PAR_EN    = 3;
  localparam int         LFC_STOP      = 2;
  localparam int         EFR_ENH       = 4;
  localparam int         CTRL_FIFO     = 0;
  localparam int         NSRC          = 7;
  localparam int         SRC_XOFF      = 5;
  localparam int         SRC_FLOW      = 6;
  localparam logic [5:0] CODE_NONE     = 6'h01;
  localparam logic [NSRC-1:0][5:0] CODES = {6'h20, 6'h10, 6'h00, 6'h02, 6'h0c, 6'h04, 6'h06};
  localparam logic [NSRC-1:0] ENH_SRCS = 7'h60;
  localparam logic [3:0] WLEN_BASE     = 4'h5;
  localparam logic [1:0] WLEN_5        = 2'h0;
  localparam logic [2:0] STOP_ONE      = 3'h2;
  localparam logic [2:0] STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_TWO      = 3'h4;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  function automatic logic [5:0] code_of(input logic [NSRC-1:0] oh);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < NSRC; i++) begin
      if (oh[i]) begin
        c = c | CODES[i];
      end
    end
    return c;
  endfunction
endpackage

//--- rtl/uis_int_prio.sv
// ranks pending sources and holds the reported one until it is serviced, then waits for a re-read
`timescale 1ns/1ps
`default_nettype none
module uis_int_prio (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  uis_if.prio       bus
);
  typedef enum logic [2:0] {
    UIS_IDLE = 3'b001,
    UIS_HELD = 3'b010,
    UIS_DONE = 3'b100
  } uis_prio_t;

  uis_prio_t                 state;
  uis_prio_t                 next_state;
  logic [uis_pkg::NSRC-1:0]  held;
  logic [uis_pkg::NSRC-1:0]  next_held;
  wire  [uis_pkg::NSRC-1:0]  act;
  wire  [uis_pkg::NSRC-1:0]  top_oh;
  wire                       any;
  wire                       held_act;

  assign act      = bus.src & (bus.enh ? {uis_pkg::NSRC{1'b1}} : ~uis_pkg::ENH_SRCS);
  assign top_oh   = act & (~act + 7'h01);
  assign any      = |act;
  assign held_act = (state == UIS_HELD) && |(held & act);
  // a serviced source that is followed by another active one must keep the line up
  assign bus.pending = held_act | any;
  assign bus.code = held_act ? uis_pkg::code_of(held)
                  : (any ? uis_pkg::code_of(top_oh) : uis_pkg::CODE_NONE);

  always_comb begin
    next_state = state;
    next_held  = held;
    unique case (state)
      UIS_IDLE: begin
        if (any) begin
          next_state = UIS_HELD;
          next_held  = top_oh;
        end
      end
      UIS_HELD: begin
        if (held_act) begin
          next_state = UIS_HELD;
        end else if (bus.rd_ident) begin
          next_state = any ? UIS_HELD : UIS_IDLE;
          next_held  = top_oh;
        end else begin
          next_state = UIS_DONE;
        end
      end
      UIS_DONE: begin
        if (bus.rd_ident) begin
          next_state = any ? UIS_HELD : UIS_IDLE;
          next_held  = top_oh;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= UIS_IDLE;
      held  <= 7'h00;
    end else begin
      state <= next_state;
      held  <= next_held;
    end
  end
endmodule
`default_nettype wire

//--- rtl/uis_line_fmt.sv
// decodes the line format control byte into framing settings
`timescale 1ns/1ps
`default_nettype none
module uis_line_fmt (
  uis_if.fmt bus
);
  assign bus.dlab      = bus.lfc[uis_pkg::LFC_DLAB];
  assign bus.brk       = bus.lfc[uis_pkg::LFC_BRK];
  assign bus.par_en    = bus.lfc[uis_pkg::LFC_PAR_EN];
  assign bus.par_kind  = bus.lfc[5:4];
  assign bus.data_bits = uis_pkg::WLEN_BASE + {2'h0, bus.lfc[1:0]};
  assign bus.stop_half = !bus.lfc[uis_pkg::LFC_STOP] ? uis_pkg::STOP_ONE
                       : (bus.lfc[1:0] == uis_pkg::WLEN_5) ? uis_pkg::STOP_ONE_HALF
                       : uis_pkg::STOP_TWO;
endmodule
`default_nettype wire

//--- rtl/uis_top.sv
// interrupt identification and line format registers behind an axi4-lite slave
//
// Summary of operation
// - pending sources are ranked into six levels; ident read gives the held one, else the highest.
// - while one source is held pending, no other source is reported.
// - receiver line status is level 1, code 000110.
// - receive data available is level 2 code 000100; time-out level 2 code 001100.
// - transmit holding empty is level 3, code 000010.
// - modem status change is level 4, code 000000.
// - xoff or special character match is level 5, code 010000.
// - flow signal change of state is level 6, code 100000.
// - ident bits 5 and 4 only active when enhanced enable bit is set.
// - xoff indication stays set until xon is received, not cleared by reads.
// - ident bits 7 and 6 read one with fifos enabled, else zero.
// - ident bit 0 is zero when pending, one when idle and after reset.
// - format bit 7 opens access to divisor latch and enhanced register.
// - format bit 6 forces transmit output low until cleared.
// - format bits 5..3 choose none, odd, even, forced one, forced zero parity.
// - format bit 2 gives one stop, or 1.5 for 5-bit, 2 otherwise.
// - format bits 1..0 set character length for transmit and receive.
// - length codes 00..11 mean 5, 6, 7, 8 data bits.
`timescale 1ns/1ps
`default_nettype none
module uis_top (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic [2:0]  i_awprot,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic [2:0]  i_arprot,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_src_line_status,
  input  wire logic        i_src_rx_data,
  input  wire logic        i_src_rx_timeout,
  input  wire logic        i_src_thr_empty,
  input  wire logic        i_src_modem,
  input  wire logic        i_xoff_match,
  input  wire logic        i_xon_rx,
  input  wire logic        i_src_flow_change,
  input  wire logic        i_tx_serial,
  output logic             o_tx,
  output logic [3:0]       o_data_bits,
  output logic             o_parity_en,
  output logic [1:0]       o_parity_kind,
  output logic [2:0]       o_stop_half_bits,
  output logic             o_div_access,
  output logic [15:0]      o_divisor,
  output logic             o_enh_enable,
  output logic             o_fifo_enable,
  output logic             o_int,
  output logic             o_irq
);
  uis_if u_bus ();

  logic [7:0]  lfc;
  logic [7:0]  enhanced_feature_reg;
  logic [15:0] divisor;
  logic [7:0]  ctrl;
  logic [6:0]  evt;
  logic [6:0]  mask;
  logic [6:0]  src_prev;
  logic        xoff_hold;
  logic        aw_full;
  logic        w_full;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  uis_int_prio u_prio (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .bus      (u_bus)
  );

  uis_line_fmt u_fmt (
    .bus (u_bus)
  );

  // write channel: address and data may arrive in either order
  wire        aw_take    = i_awvalid & o_awready;
  wire        w_take     = i_wvalid & o_wready;
  wire        aw_have    = aw_full | aw_take;
  wire        w_have     = w_full | w_take;
  wire        do_wr      = aw_have & w_have;
  wire [7:0]  wa         = aw_full ? aw_addr : i_awaddr;
  wire [31:0] wd         = w_full ? w_data : i_wdata;
  wire [3:0]  ws         = w_full ? w_strb : i_wstrb;
  wire        next_aw_full = aw_have & ~do_wr;
  wire        next_w_full  = w_have & ~do_wr;
  wire        next_bvalid  = do_wr | (o_bvalid & ~i_bready);

  wire        dlab       = u_bus.dlab;
  wire        wr_lfc     = do_wr && (wa == uis_pkg::OFF_LFC) && ws[0];
  wire        wr_efr     = do_wr && (wa == uis_pkg::OFF_EFR) && ws[0] && dlab;
  wire        wr_div_lo  = do_wr && (wa == uis_pkg::OFF_DIV) && ws[0] && dlab;
  wire        wr_div_hi  = do_wr && (wa == uis_pkg::OFF_DIV) && ws[1] && dlab;
  wire        wr_ctrl    = do_wr && (wa == uis_pkg::OFF_CTRL) && ws[0];
  wire        wr_evt     = do_wr && (wa == uis_pkg::OFF_EVT) && ws[0];
  wire        wr_mask    = do_wr && (wa == uis_pkg::OFF_MASK) && ws[0];
  wire        wa_hit     = (wa == uis_pkg::OFF_IDENT) || (wa == uis_pkg::OFF_LFC)
                        || (wa == uis_pkg::OFF_EFR) || (wa == uis_pkg::OFF_DIV)
                        || (wa == uis_pkg::OFF_CTRL) || (wa == uis_pkg::OFF_EVT)
                        || (wa == uis_pkg::OFF_MASK);

  // read channel
  wire        ar_take    = i_arvalid & o_arready;
  wire        next_rvalid = ar_take | (o_rvalid & ~i_rready);
  wire        rd_ident   = ar_take && (i_araddr == uis_pkg::OFF_IDENT);
  wire        enh        = enhanced_feature_reg[uis_pkg::EFR_ENH];
  wire        fifo_en    = ctrl[uis_pkg::CTRL_FIFO];
  wire [5:0]  code       = u_bus.code;
  wire [7:0]  ident      = {fifo_en, fifo_en, code[5:4] & {2{enh}}, code[3:0]};
  wire        ar_hit     = (i_araddr == uis_pkg::OFF_IDENT) || (i_araddr == uis_pkg::OFF_LFC)
                        || (i_araddr == uis_pkg::OFF_EFR) || (i_araddr == uis_pkg::OFF_DIV)
                        || (i_araddr == uis_pkg::OFF_CTRL) || (i_araddr == uis_pkg::OFF_EVT)
                        || (i_araddr == uis_pkg::OFF_MASK);
  wire [31:0] rd_val     = (i_araddr == uis_pkg::OFF_IDENT) ? {24'h000000, ident}
                         : (i_araddr == uis_pkg::OFF_LFC)   ? {24'h000000, lfc}
                         : (i_araddr == uis_pkg::OFF_EFR)   ? {24'h000000, dlab ? enhanced_feature_reg : 8'h00}
                         : (i_araddr == uis_pkg::OFF_DIV)   ? {16'h0000, dlab ? divisor : 16'h0000}
                         : (i_araddr == uis_pkg::OFF_CTRL)  ? {24'h000000, ctrl}
                         : (i_araddr == uis_pkg::OFF_EVT)   ? {25'h0000000, evt}
                         : (i_araddr == uis_pkg::OFF_MASK)  ? {25'h0000000, mask}
                         : 32'h00000000;

  // xoff indication held until xon; set wins over a coincident xon
  wire        next_xoff  = (i_xoff_match & enh) | (xoff_hold & ~i_xon_rx);
  wire [6:0]  src        = {i_src_flow_change, xoff_hold, i_src_modem, i_src_thr_empty,
                            i_src_rx_timeout, i_src_rx_data, i_src_line_status};
  wire [6:0]  src_rise   = src & ~src_prev;
  wire [6:0]  next_evt   = (evt & ~(wr_evt ? wd[6:0] : 7'h00)) | src_rise;

  assign u_bus.src      = src;
  assign u_bus.enh      = enh;
  assign u_bus.rd_ident = rd_ident;
  assign u_bus.lfc      = lfc;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      aw_addr   <= 8'h00;
      w_data    <= 32'h00000000;
      w_strb    <= 4'h0;
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= uis_pkg::RESP_OKAY;
    end else begin
      aw_full   <= next_aw_full;
      w_full    <= next_w_full;
      o_awready <= ~next_aw_full & ~next_bvalid;
      o_wready  <= ~next_w_full & ~next_bvalid;
      o_bvalid  <= next_bvalid;
      if (aw_take) begin
        aw_addr <= i_awaddr;
      end
      if (w_take) begin
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_wr) begin
        o_bresp <= wa_hit ? uis_pkg::RESP_OKAY : uis_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= uis_pkg::RESP_OKAY;
    end else begin
      o_arready <= ~next_rvalid;
      o_rvalid  <= next_rvalid;
      if (ar_take) begin
        o_rdata <= rd_val;
        o_rresp <= ar_hit ? uis_pkg::RESP_OKAY : uis_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lfc     <= uis_pkg::LFC_RST;
      enhanced_feature_reg     <= uis_pkg::EFR_RST;
      divisor <= uis_pkg::DIV_RST;
      ctrl    <= uis_pkg::CTRL_RST;
      mask    <= 7'h00;
    end else begin
      if (wr_lfc) begin
        lfc <= wd[7:0];
      end
      if (wr_efr) begin
        enhanced_feature_reg <= wd[7:0];
      end
      if (wr_div_lo) begin
        divisor[7:0] <= wd[7:0];
      end
      if (wr_div_hi) begin
        divisor[15:8] <= wd[15:8];
      end
      if (wr_ctrl) begin
        ctrl <= wd[7:0];
      end
      if (wr_mask) begin
        mask <= wd[6:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      xoff_hold <= 1'b0;
      src_prev  <= 7'h00;
      evt       <= 7'h00;
      o_irq     <= 1'b0;
    end else begin
      xoff_hold <= next_xoff;
      src_prev  <= src;
      evt       <= next_evt;
      o_irq     <= |(next_evt & mask);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx             <= 1'b1;
      o_data_bits      <= uis_pkg::WLEN_BASE;
      o_parity_en      <= 1'b0;
      o_parity_kind    <= 2'h0;
      o_stop_half_bits <= uis_pkg::STOP_ONE;
      o_div_access     <= 1'b0;
      o_divisor        <= uis_pkg::DIV_RST;
      o_enh_enable     <= 1'b0;
      o_fifo_enable    <= 1'b0;
      o_int            <= 1'b0;
    end else begin
      o_tx             <= u_bus.brk ? 1'b0 : i_tx_serial;
      o_data_bits      <= u_bus.data_bits;
      o_parity_en      <= u_bus.par_en;
      o_parity_kind    <= u_bus.par_kind;
      o_stop_half_bits <= u_bus.stop_half;
      o_div_access     <= dlab;
      o_divisor        <= divisor;
      o_enh_enable     <= enh;
      o_fifo_enable    <= fifo_en;
      o_int            <= u_bus.pending;
    end
  end
endmodule
`default_nettype wire

//--- verification/test_uart_int_status_line_format.sv
// register and interrupt ranking tests over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module test_uart_int_status_line_format;
  logic        i_clk, i_arst_n, awvalid, wvalid, bready, arvalid, rready, run, prev;
  logic        awready, wready, bvalid, arready, rvalid, tx, line, pe, de, ee, fe, oi, irq;
  logic [7:0]  awaddr, araddr, s;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, pk;
  logic [3:0]  db;
  logic [2:0]  sh;
  logic [15:0] dv;
  int          num_errors, samples_checked, cyc;
  logic [5:0]  code [7] = '{6'h06, 6'h04, 6'h0c, 6'h02, 6'h00, 6'h10, 6'h20};
  logic [7:0]  pseq [7] = '{8'h1f, 8'h1e, 8'h00, 8'h08, 8'h09, 8'h01, 8'h00};
  logic [7:0]  pexp [7] = '{8'h06, 8'h04, 8'h01, 8'h02, 8'h02, 8'h06, 8'h01};

  uis_top uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_awaddr(awaddr), .i_awprot(3'h0), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arprot(3'h0), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_src_line_status(s[0]), .i_src_rx_data(s[1]), .i_src_rx_timeout(s[2]), .i_src_thr_empty(s[3]),
    .i_src_modem(s[4]), .i_xoff_match(s[5]), .i_src_flow_change(s[6]), .i_xon_rx(s[7]), .i_tx_serial(line),
    .o_tx(tx), .o_data_bits(db), .o_parity_en(pe), .o_parity_kind(pk), .o_stop_half_bits(sh),
    .o_div_access(de), .o_divisor(dv), .o_enh_enable(ee), .o_fifo_enable(fe), .o_int(oi), .o_irq(irq));
  uis_line_peer peer (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_run(run), .o_line(line));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cy(input int k);
    repeat (k) @(posedge i_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    chk(bvalid, 1'b1);
    chk(bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    chk(rvalid, 1'b1);
    chk(rdata, e);
    chk(rresp, er);
  endtask

  initial begin
    i_arst_n <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, run} <= '0;
    {awaddr, araddr, s, wdata} <= '0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    cy(1);
    rd(8'h00, 32'h01, 2'h0);
    rd(8'h04, 32'h00, 2'h0);
    rd(8'h1c, 32'h00, 2'h2);
    wr(8'h02, 32'h01, 2'h2);
    wr(8'h08, 32'h20, 2'h0);
    wr(8'h04, 32'h80, 2'h0);
    rd(8'h08, 32'h00, 2'h0);
    wr(8'h08, 32'h10, 2'h0);
    wr(8'h0c, 32'h1234, 2'h0);
    rd(8'h08, 32'h10, 2'h0);
    rd(8'h0c, 32'h1234, 2'h0);
    cy(1);
    chk({de, ee, dv}, {2'b11, 16'h1234});
    wr(8'h04, 32'h00, 2'h0);
    rd(8'h08, 32'h00, 2'h0);
    chk(de, 1'b0);
    for (int i = 0; i < 7; i++) begin
      s <= 8'h01 << i;
      cy(4);
      chk(oi, 1'b1);
      rd(8'h00, {26'h0, code[i]}, 2'h0);
      s <= 8'h00;
      cy(4);
      if (i == 5) begin
        rd(8'h00, 32'h10, 2'h0);
        s <= 8'h80;
        cy(1);
        s <= 8'h00;
        cy(3);
      end
      rd(8'h00, 32'h01, 2'h0);
      chk(oi, 1'b0);
    end
    for (int i = 0; i < 7; i++) begin
      s <= pseq[i];
      cy(4);
      chk(oi, pexp[i] != 8'h01);
      rd(8'h00, {24'h0, pexp[i]}, 2'h0);
    end
    rd(8'h14, 32'h7f, 2'h0);
    chk(irq, 1'b0);
    wr(8'h18, 32'h04, 2'h0);
    cy(1);
    chk(irq, 1'b1);
    wr(8'h14, 32'h7b, 2'h0);
    rd(8'h14, 32'h04, 2'h0);
    chk(irq, 1'b1);
    wr(8'h14, 32'h04, 2'h0);
    cy(1);
    chk(irq, 1'b0);
    wr(8'h04, 32'h80, 2'h0);
    wr(8'h08, 32'h00, 2'h0);
    wr(8'h04, 32'h00, 2'h0);
    s <= 8'h60;
    cy(4);
    chk(oi, 1'b0);
    rd(8'h00, 32'h01, 2'h0);
    s <= 8'h00;
    wr(8'h10, 32'h01, 2'h0);
    rd(8'h00, 32'hc1, 2'h0);
    chk(fe, 1'b1);
    wr(8'h10, 32'h00, 2'h0);
    for (int v = 0; v < 64; v++) begin
      wr(8'h04, 32'(v), 2'h0);
      cy(1);
      chk(db, 4'h5 + v[1:0]);
      chk(sh, v[2] ? (v[1:0] == 2'h0 ? 3'h3 : 3'h4) : 3'h2);
      chk({pe, pk}, {v[3], v[5:4]});
      rd(8'h04, 32'(v), 2'h0);
    end
    run <= 1'b1;
    wr(8'h04, 32'h40, 2'h0);
    repeat (6) begin
      cy(1);
      chk(tx, 1'b0);
    end
    wr(8'h04, 32'h03, 2'h0);
    cy(1);
    repeat (6) begin
      prev = line;
      cy(1);
      chk(tx, prev);
    end
    print_verdict();
  end
endmodule
`default_nettype wire

//--- verification/uis_line_peer.sv
// serial line source feeding the transmit path
`timescale 1ns/1ps
`default_nettype none
module uis_line_peer (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_run,
  output logic      o_line
);
  // idles high, changes every cycle inside a frame so a stuck path shows
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_line <= 1'b1;
    end else begin
      o_line <= i_run ? ~o_line : 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- verification/uis_top_asserts.sv
// port-level assertions for the identification and line format top
`timescale 1ns/1ps
`default_nettype none
module uis_top_asserts (
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_bready,
  input wire logic        i_rready,
  input wire logic        o_bvalid,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_rvalid,
  input wire logic [1:0]  o_rresp,
  input wire logic [31:0] o_rdata,
  input wire logic        i_src_line_status,
  input wire logic        i_src_rx_data,
  input wire logic        i_src_rx_timeout,
  input wire logic        i_src_thr_empty,
  input wire logic        i_src_modem,
  input wire logic        i_tx_serial,
  input wire logic        o_tx,
  input wire logic [3:0]  o_data_bits,
  input wire logic [2:0]  o_stop_half_bits,
  input wire logic        o_enh_enable,
  input wire logic        o_int
);
  wire logic no_src = !(i_src_line_status | i_src_rx_data | i_src_rx_timeout | i_src_thr_empty | i_src_modem)
                      && !o_enh_enable;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before bready");
  a_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read data dropped before rready");
  a_slverr_zero: assert property (o_rvalid && o_rresp == 2'h2 |-> o_rdata == 32'h0)
    else $error("refused read returned data");
  a_int_idle: assert property (no_src [*2] |=> !o_int)
    else $error("interrupt high with no source");
  a_int_rise: assert property ($rose(i_src_line_status) ##1 i_src_line_status [*3] |-> o_int)
    else $error("interrupt missing for line status");
  a_len_range: assert property (o_data_bits >= 4'h5 && o_data_bits <= 4'h8)
    else $error("character length out of range");
  a_stop_half: assert property (o_stop_half_bits == 3'h3 |-> o_data_bits == 4'h5)
    else $error("one and a half stop bits with long word");
  a_stop_two: assert property (o_stop_half_bits == 3'h4 |-> o_data_bits != 4'h5)
    else $error("two stop bits with 5-bit word");
  a_tx_follow: assert property (o_tx && $past(i_arst_n) |-> $past(i_tx_serial))
    else $error("transmit line high without serial high");
endmodule
bind uis_top uis_top_asserts u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_bready(i_bready), .i_rready(i_rready),
  .o_bvalid(o_bvalid), .o_bresp(o_bresp), .o_rvalid(o_rvalid), .o_rresp(o_rresp), .o_rdata(o_rdata),
  .i_src_line_status(i_src_line_status), .i_src_rx_data(i_src_rx_data), .i_src_rx_timeout(i_src_rx_timeout),
  .i_src_thr_empty(i_src_thr_empty), .i_src_modem(i_src_modem), .i_tx_serial(i_tx_serial), .o_tx(o_tx),
  .o_data_bits(o_data_bits), .o_stop_half_bits(o_stop_half_bits), .o_enh_enable(o_enh_enable), .o_int(o_int));
`default_nettype wire
